// [tac_i2c_port.sv]
/*
  Two-wire slave command port of the touch digitizer: address match, command
  byte capture, acquisition window, result read-out and clock stretching in
  high-speed mode. Instantiates the core-domain conversion sequencer.
  Assumes linkClk oversamples SCL and SDA well above the bus bit rate, and
  that the pad ring resolves the open-drain wires from the enables.
*/
//
// Functional notes
// - Acknowledge matching address with write direction; starts a write cycle.
// - Exactly one command byte is acknowledged; STOP or repeated START ends it.
// - Further command bytes in the same write cycle get no acknowledge.
// - Codes 0-2, 4-6 measure single-ended inputs with drivers off.
// - Codes 8-10 only switch drivers, differential; 3, 7, 11 reserved.
// - Codes 12-15 measure positions with their drivers on from acquisition.
// - Channel follows shifted bits; acquisition from falling edge after last bit.
// - Conversion follows acquisition; inputs disconnected, position drivers stay on.
// - Matching read address is acknowledged, then upper result bits MSB first.
// - After master acknowledge, lower result bits followed by four zeros.
// - Master nacks second byte; acknowledged reads repeat the same bytes.
// - High-speed code after START is not acknowledged; mode lasts until STOP.
// - High-speed read before conversion end holds SCL low until latched.
// - Results are unsigned straight binary.
// - Mode bit set gives shorter 8-bit conversions, one read byte suffices.
// - Mode bit selects 12-bit when clear, 8-bit when set.
// - Power-down field sets the power state after the current command.
// - Reference power latches only when STOP or repeated START closes command.
// - Two address bits come from the device select pins.
`timescale 1ns/1ps
`include "tac_consts.svh"

module tac_i2c_port
  import tac_pkg::*;
#(
  parameter logic [4:0] ADDR_PREFIX = `TAC_PREFIX_DEFAULT, // Arbitrary value
  parameter int         BIT_CYCLES  = `TAC_BIT_CYCLES_DEF  // Core cycles per decision
) (
  input  wire logic        core_clk,         // Core clock, 10 MHz
  input  wire logic        reset_n,          // Synchronous reset, active low
  input  wire logic        linkClk,          // Bus sampling clock
  input  wire logic        sclIn,            // SCL wire level
  output logic             sclOut,           // SCL drive value, always low
  output logic             sclOe,            // SCL pulled low (stretch)
  input  wire logic        sdaIn,            // SDA wire level
  output logic             sdaOut,           // SDA drive value, always low
  output logic             sdaOe,            // SDA pulled low
  input  wire logic [1:0]  deviceSelectPins, // Address select straps
  input  wire logic [11:0] adcResult,        // Converter output code
  output logic [3:0]       muxSel,           // Converter input select
  output logic             muxEnable,        // Converter input connected
  output logic [3:0]       panelDrivers,     // {X+, X-, Y+, Y-} drivers on
  output logic             refDifferential,  // Differential reference mode
  output logic             convActive,       // Conversion running
  output logic             eightBitMode,     // Short conversion selected
  output logic             refPowerOn,       // Internal reference powered
  output logic             adcPowerOn,       // Converter powered
  output logic             hsMode            // High-speed mode active
);

  localparam logic [4:0] HS_CODE = `TAC_HS_CODE;

  if (ADDR_PREFIX[4:1] == HS_CODE[4:1]) begin : g_check
    $error("ADDR_PREFIX collides with the high-speed code");
  end

  // Link-domain reset and input synchronisers
  logic               rstS1_q, rstLink_n;
  logic               sclS1_q, sclS2_q, sclPrev_q;
  logic               sdaS1_q, sdaS2_q, sdaPrev_q;
  logic [1:0]         selS1_q, selS2_q;
  logic               doneS1_q, doneS2_q, donePrev_q;
  logic               doneTgl;
  logic [11:0]        coreResult;

  // Link-domain state
  tac_link_state_type state_q;
  logic [3:0]         bitCnt_q;
  logic [7:0]         shift_q;
  logic               rw_q;
  logic               ackOk_q;
  logic               byteSel_q;
  logic               acquire_q;
  logic [3:0]         chanSel_q;
  logic [7:0]         cmd_q;
  logic               convReqTgl_q;
  logic               convPending_q;
  logic [11:0]        rdResult_q;

  logic               sclRise, sclFall, startCond, stopCond, doneEdge;
  logic               byteEnd, addrMatch, hsCode;
  logic [7:0]         firstByte, nextByte;

  function automatic logic [7:0] read_byte(input logic sel, input logic [11:0] res);
    read_byte = sel ? {res[3:0], `TAC_FILL_NIBBLE} : res[11:4];
  endfunction

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  always_ff @(posedge linkClk) begin
    rstS1_q   <= reset_n;
    rstLink_n <= rstS1_q;
  end

  always_ff @(posedge linkClk) begin
    if (!rstLink_n) begin
      sclS1_q    <= 1'b1;
      sclS2_q    <= 1'b1;
      sclPrev_q  <= 1'b1;
      sdaS1_q    <= 1'b1;
      sdaS2_q    <= 1'b1;
      sdaPrev_q  <= 1'b1;
      selS1_q    <= 2'b00;
      selS2_q    <= 2'b00;
      doneS1_q   <= 1'b0;
      doneS2_q   <= 1'b0;
      donePrev_q <= 1'b0;
    end else begin
      sclS1_q    <= sclIn;
      sclS2_q    <= sclS1_q;
      sclPrev_q  <= sclS2_q;
      sdaS1_q    <= sdaIn;
      sdaS2_q    <= sdaS1_q;
      sdaPrev_q  <= sdaS2_q;
      selS1_q    <= deviceSelectPins;
      selS2_q    <= selS1_q;
      doneS1_q   <= doneTgl;
      doneS2_q   <= doneS1_q;
      donePrev_q <= doneS2_q;
    end
  end

  assign sclRise   = sclS2_q & ~sclPrev_q;
  assign sclFall   = ~sclS2_q & sclPrev_q;
  assign startCond = sclS2_q & sclPrev_q & sdaPrev_q & ~sdaS2_q;
  assign stopCond  = sclS2_q & sclPrev_q & ~sdaPrev_q & sdaS2_q;
  assign doneEdge  = doneS2_q ^ donePrev_q;
  assign byteEnd   = sclFall & (bitCnt_q == `TAC_BYTE_BITS);
  assign addrMatch = (shift_q[7:1] == {ADDR_PREFIX, selS2_q});
  assign hsCode    = (shift_q[7:3] == `TAC_HS_CODE);
  assign firstByte = read_byte(1'b0, rdResult_q);
  assign nextByte  = read_byte(~byteSel_q, rdResult_q);

  // Bus protocol engine
  always_ff @(posedge linkClk) begin
    if (!rstLink_n) begin
      state_q   <= LINK_IDLE;
      bitCnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      rw_q      <= 1'b0;
      ackOk_q   <= 1'b0;
      byteSel_q <= 1'b0;
      sdaOe     <= 1'b0;
      sclOe     <= 1'b0;
    end else if (stopCond) begin
      state_q <= LINK_IDLE;
      sdaOe   <= 1'b0;
      sclOe   <= 1'b0;
    end else if (startCond) begin
      state_q  <= LINK_ADDR;
      bitCnt_q <= 4'h0;
      sdaOe    <= 1'b0;
      sclOe    <= 1'b0;
    end else begin
      unique case (state_q)
        LINK_IDLE: begin
          sdaOe <= 1'b0;
        end
        LINK_ADDR: begin
          if (sclRise) begin
            shift_q  <= {shift_q[6:0], sdaS2_q};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (byteEnd) begin
            if (addrMatch && !hsCode) begin
              sdaOe   <= 1'b1;
              rw_q    <= shift_q[0];
              state_q <= LINK_ADDR_ACK;
            end else begin
              state_q <= LINK_IDLE;
            end
          end
        end
        LINK_ADDR_ACK: begin
          if (sclFall) begin
            byteSel_q <= 1'b0;
            if (!rw_q) begin
              sdaOe    <= 1'b0;
              bitCnt_q <= 4'h0;
              state_q  <= LINK_CMD;
            end else if (hsMode && convPending_q) begin
              sdaOe   <= 1'b0;
              sclOe   <= 1'b1;
              state_q <= LINK_RD_WAIT;
            end else begin
              shift_q  <= firstByte;
              sdaOe    <= ~firstByte[7];
              bitCnt_q <= 4'h1;
              state_q  <= LINK_RD_BYTE;
            end
          end
        end
        LINK_CMD: begin
          if (sclRise) begin
            shift_q  <= {shift_q[6:0], sdaS2_q};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (byteEnd) begin
            sdaOe   <= 1'b1;
            state_q <= LINK_CMD_ACK;
          end
        end
        LINK_CMD_ACK: begin
          if (sclFall) begin
            sdaOe   <= 1'b0;
            state_q <= LINK_CMD_EXTRA;
          end
        end
        LINK_CMD_EXTRA: begin
          sdaOe <= 1'b0;
        end
        LINK_RD_WAIT: begin
          if (!convPending_q) begin
            shift_q  <= firstByte;
            sdaOe    <= ~firstByte[7];
            bitCnt_q <= 4'h1;
            state_q  <= LINK_RD_BYTE;
          end
        end
        LINK_RD_BYTE: begin
          // Clock is let go one cycle after the first data bit settles
          sclOe <= 1'b0;
          if (byteEnd) begin
            sdaOe   <= 1'b0;
            state_q <= LINK_RD_ACK;
          end else if (sclFall) begin
            sdaOe    <= ~shift_q[6];
            shift_q  <= {shift_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        LINK_RD_ACK: begin
          if (sclRise) begin
            ackOk_q <= ~sdaS2_q;
          end else if (sclFall) begin
            if (ackOk_q) begin
              byteSel_q <= ~byteSel_q;
              shift_q   <= nextByte;
              sdaOe     <= ~nextByte[7];
              bitCnt_q  <= 4'h1;
              state_q   <= LINK_RD_BYTE;
            end else begin
              state_q <= LINK_IDLE;
            end
          end
        end
        default: begin
          state_q <= LINK_IDLE;
          sdaOe   <= 1'b0;
          sclOe   <= 1'b0;
        end
      endcase
    end
  end

  // Command capture and acquisition window
  always_ff @(posedge linkClk) begin
    if (!rstLink_n) begin
      chanSel_q    <= 4'h0;
      cmd_q        <= 8'h00;
      acquire_q    <= 1'b0;
      convReqTgl_q <= 1'b0;
    end else begin
      if (state_q == LINK_CMD && sclRise && bitCnt_q == `TAC_CHAN_LAST_BIT) begin
        chanSel_q <= {shift_q[2:0], sdaS2_q};
      end
      if (state_q == LINK_CMD && byteEnd) begin
        cmd_q <= shift_q;
      end
      if (startCond || stopCond) begin
        if (acquire_q) begin
          acquire_q    <= 1'b0;
          convReqTgl_q <= ~convReqTgl_q;
        end
      end else if (state_q == LINK_CMD && sclFall && bitCnt_q == `TAC_CHAN_BITS_DONE) begin
        acquire_q <= 1'b1;
      end
    end
  end

  // Conversion tracking and result hand-off from the core domain
  always_ff @(posedge linkClk) begin
    if (!rstLink_n) begin
      convPending_q <= 1'b0;
      rdResult_q    <= 12'h000;
      hsMode        <= 1'b0;
    end else begin
      if ((startCond || stopCond) && acquire_q) begin
        convPending_q <= 1'b1;
      end else if (doneEdge) begin
        convPending_q <= 1'b0;
      end
      if (doneEdge) begin
        rdResult_q <= coreResult;
      end
      if (stopCond) begin
        hsMode <= 1'b0;
      end else if (state_q == LINK_ADDR && byteEnd && hsCode) begin
        hsMode <= 1'b1;
      end
    end
  end

  tac_conv_seq #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_conv (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .convReqTgl      (convReqTgl_q),
    .acquireLink     (acquire_q),
    .chanLink        (chanSel_q),
    .cmdLink         (cmd_q),
    .adcResult       (adcResult),
    .doneTgl         (doneTgl),
    .resultWord      (coreResult),
    .muxSel          (muxSel),
    .muxEnable       (muxEnable),
    .panelDrivers    (panelDrivers),
    .refDifferential (refDifferential),
    .convActive      (convActive),
    .eightBitMode    (eightBitMode),
    .refPowerOn      (refPowerOn),
    .adcPowerOn      (adcPowerOn)
  );

endmodule

// [tac_consts.svh]
/*
  Constants of the touch digitizer command port: command byte fields, address
  layout, read byte layout and conversion timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH

// Command byte, most significant bit first on the wire
`define TAC_CMD_CHAN_HI      3'd7
`define TAC_CMD_CHAN_LO      3'd4
`define TAC_CMD_REF_PWR      3'd3
`define TAC_CMD_CONV_PWR     3'd2
`define TAC_CMD_MODE         3'd1

// Bit counts within a byte transfer
`define TAC_BYTE_BITS        4'd8
`define TAC_CHAN_LAST_BIT    4'd3
`define TAC_CHAN_BITS_DONE   4'd4

// Address byte
`define TAC_PREFIX_DEFAULT   5'h0d
`define TAC_HS_CODE          5'h01

// Conversion length in bit decisions, and core cycles per decision
`define TAC_DECISIONS_FULL   4'd12
`define TAC_DECISIONS_SHORT  4'd8
`define TAC_BIT_CYCLES_DEF   8

// Zero fill of the second read byte
`define TAC_FILL_NIBBLE      4'h0

`endif

// [tac_pkg.sv]
/*
  Types and shared decoding of the touch digitizer command port.
  Assumes tac_consts.svh is reachable on the include path.
*/
`include "tac_consts.svh"

package tac_pkg;

  typedef enum logic [3:0] {
    LINK_IDLE      = 4'b0000,
    LINK_ADDR      = 4'b0001,
    LINK_ADDR_ACK  = 4'b0010,
    LINK_CMD       = 4'b0011,
    LINK_CMD_ACK   = 4'b0100,
    LINK_CMD_EXTRA = 4'b0101,
    LINK_RD_WAIT   = 4'b0110,
    LINK_RD_BYTE   = 4'b0111,
    LINK_RD_ACK    = 4'b1000
  } tac_link_state_type;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_RUN  = 1'b1
  } tac_conv_state_type;

  typedef enum logic [3:0] {
    CH_TEMP_SENSOR_A  = 4'b0000,
    CH_BATTERY_A      = 4'b0001,
    CH_AUX_A          = 4'b0010,
    CH_TEMP_SENSOR_B  = 4'b0100,
    CH_BATTERY_B      = 4'b0101,
    CH_AUX_B          = 4'b0110,
    CH_DRIVE_X        = 4'b1000,
    CH_DRIVE_Y        = 4'b1001,
    CH_DRIVE_YP_XM    = 4'b1010,
    CH_POS_X          = 4'b1100,
    CH_POS_Y          = 4'b1101,
    CH_POS_Z1         = 4'b1110,
    CH_POS_Z2         = 4'b1111
  } tac_chan_type;

  // Panel driver set for a code: {xPlus, xMinus, yPlus, yMinus}
  function automatic logic [3:0] tac_drivers(input logic [3:0] code);
    case (code)
      CH_DRIVE_X, CH_POS_X:                       tac_drivers = 4'b1100;
      CH_DRIVE_Y, CH_POS_Y:                       tac_drivers = 4'b0011;
      CH_DRIVE_YP_XM, CH_POS_Z1, CH_POS_Z2:       tac_drivers = 4'b0110;
      default:                                    tac_drivers = 4'b0000;
    endcase
  endfunction

  // Codes that route an input to the converter
  function automatic logic tac_is_measure(input logic [3:0] code);
    tac_is_measure = (code[3] == 1'b0) ? (code[1:0] != 2'b11) : code[2];
  endfunction

  function automatic logic tac_is_position(input logic [3:0] code);
    tac_is_position = code[3] & code[2];
  endfunction

endpackage

// [tac_conv_seq.sv]
/*
  Conversion sequencer in the core clock domain: acquisition and conversion
  control, panel drivers, power state and result capture.
  Assumes the link side toggles convReqTgl with cmdLink already stable, and
  that the analog converter presents adcResult at the end of a conversion.
*/
`timescale 1ns/1ps
`include "tac_consts.svh"

module tac_conv_seq
  import tac_pkg::*;
#(
  parameter int BIT_CYCLES = `TAC_BIT_CYCLES_DEF
) (
  input  wire logic        core_clk,      // Core clock
  input  wire logic        reset_n,       // Synchronous reset, active low
  input  wire logic        convReqTgl,    // Link toggle: conversion start
  input  wire logic        acquireLink,   // Link level: acquisition window
  input  wire logic [3:0]  chanLink,      // Link channel select field
  input  wire logic [7:0]  cmdLink,       // Link command byte
  input  wire logic [11:0] adcResult,     // Converter output code
  output logic             doneTgl,       // Toggle: result latched
  output logic [11:0]      resultWord,    // Latched result
  output logic [3:0]       muxSel,        // Converter input select
  output logic             muxEnable,     // Converter input connected
  output logic [3:0]       panelDrivers,  // {X+, X-, Y+, Y-} drivers on
  output logic             refDifferential, // Differential reference mode
  output logic             convActive,    // Conversion running
  output logic             eightBitMode,  // Short conversion selected
  output logic             refPowerOn,    // Internal reference powered
  output logic             adcPowerOn     // Converter powered
);

  localparam int CNT_W = $clog2(12 * BIT_CYCLES + 1);

  if (BIT_CYCLES < 1 || BIT_CYCLES > 255) begin : g_check
    $error("BIT_CYCLES out of range");
  end

  logic               reqS1_q, reqS2_q, reqPrev_q;
  logic               acqS1_q, acqS2_q;
  logic [3:0]         chanS1_q, chanS2_q;
  logic [7:0]         cmd_q;
  logic               convPwr_q;
  logic [CNT_W-1:0]   cnt_q;
  tac_conv_state_type state_q;
  logic               reqEdge;
  logic [3:0]         cmdChan;

  assign reqEdge = reqS2_q ^ reqPrev_q;
  assign cmdChan = cmd_q[`TAC_CMD_CHAN_HI:`TAC_CMD_CHAN_LO];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reqS1_q   <= 1'b0;
      reqS2_q   <= 1'b0;
      reqPrev_q <= 1'b0;
      acqS1_q   <= 1'b0;
      acqS2_q   <= 1'b0;
      chanS1_q  <= 4'h0;
      chanS2_q  <= 4'h0;
    end else begin
      reqS1_q   <= convReqTgl;
      reqS2_q   <= reqS1_q;
      reqPrev_q <= reqS2_q;
      acqS1_q   <= acquireLink;
      acqS2_q   <= acqS1_q;
      chanS1_q  <= chanLink;
      chanS2_q  <= chanS1_q;
    end
  end

  // Conversion runs from the end of acquisition for a mode-dependent length
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q    <= CONV_IDLE;
      cnt_q      <= '0;
      cmd_q      <= 8'h00;
      resultWord <= 12'h000;
      doneTgl    <= 1'b0;
    end else begin
      unique case (state_q)
        CONV_IDLE: begin
          if (reqEdge) begin
            cmd_q   <= cmdLink;
            state_q <= CONV_RUN;
            if (cmdLink[`TAC_CMD_MODE]) begin
              cnt_q <= CNT_W'(`TAC_DECISIONS_SHORT * BIT_CYCLES);
            end else begin
              cnt_q <= CNT_W'(`TAC_DECISIONS_FULL * BIT_CYCLES);
            end
          end
        end
        CONV_RUN: begin
          cnt_q <= cnt_q - CNT_W'(1);
          if (cnt_q == CNT_W'(1)) begin
            state_q <= CONV_IDLE;
            doneTgl <= ~doneTgl;
            if (cmd_q[`TAC_CMD_MODE]) begin
              resultWord <= {adcResult[11:4], `TAC_FILL_NIBBLE};
            end else begin
              resultWord <= adcResult;
            end
          end
        end
      endcase
    end
  end

  // Power state takes effect when the command is closed
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      refPowerOn <= 1'b0;
      convPwr_q  <= 1'b0;
      adcPowerOn <= 1'b0;
    end else begin
      if (reqEdge) begin
        refPowerOn <= cmdLink[`TAC_CMD_REF_PWR];
        convPwr_q  <= cmdLink[`TAC_CMD_CONV_PWR];
      end
      adcPowerOn <= convPwr_q | acqS2_q | (state_q == CONV_RUN);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      muxSel          <= 4'h0;
      muxEnable       <= 1'b0;
      panelDrivers    <= 4'h0;
      refDifferential <= 1'b0;
      convActive      <= 1'b0;
      eightBitMode    <= 1'b0;
    end else begin
      muxSel          <= chanS2_q;
      muxEnable       <= acqS2_q & tac_is_measure(chanS2_q);
      refDifferential <= acqS2_q ? chanS2_q[3] : cmdChan[3];
      convActive      <= (state_q == CONV_RUN);
      eightBitMode    <= cmd_q[`TAC_CMD_MODE];
      if (acqS2_q) begin
        panelDrivers <= tac_drivers(chanS2_q);
      end else if ((state_q == CONV_RUN || convPwr_q) && tac_is_position(cmdChan)) begin
        panelDrivers <= tac_drivers(cmdChan);
      end else begin
        panelDrivers <= 4'h0;
      end
    end
  end

endmodule

// [tac_i2c_port_props.sv]
/* Checker of the command port outputs.
   Bound to tac_i2c_port; sees its ports only. */
`timescale 1ns/1ps
module tac_i2c_port_props #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic       core_clk,     // Core clock
  input wire logic       reset_n,      // Reset, active low
  input wire logic       linkClk,      // Bus sampling clock
  input wire logic       sclIn,        // SCL wire
  input wire logic       sclOe,        // SCL stretch
  input wire logic       sdaOe,        // SDA pulled low
  input wire logic [3:0] muxSel,       // Input select
  input wire logic       muxEnable,    // Input connected
  input wire logic [3:0] panelDrivers, // Drivers on
  input wire logic       convActive,   // Conversion running
  input wire logic       eightBitMode, // Short conversion
  input wire logic       adcPowerOn,   // Converter powered
  input wire logic       hsMode        // High-speed mode
);
  logic [7:0] convLen_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n || !convActive) convLen_q <= 8'h00;
    else convLen_q <= convLen_q + 8'h01;
  end
  sequence s_conv_done;
    $fell(convActive);
  endsequence
  a_conv_length: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_conv_done |-> convLen_q == (eightBitMode ? 8 : 12) * BIT_CYCLES)
    else $error("conversion length wrong");
  a_conv_mux_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    convActive |-> !muxEnable) else $error("input connected in conversion");
  a_pos_drv_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    convActive && muxSel[3:2] == 2'b11 |-> panelDrivers != 4'h0)
    else $error("position drivers off in conversion");
  a_drv_only_nomux: assert property (@(posedge core_clk) disable iff (!reset_n)
    muxEnable |-> !(muxSel[3] && !muxSel[2])) else $error("driver code connected input");
  a_conv_power: assert property (@(posedge core_clk) disable iff (!reset_n)
    convActive |-> adcPowerOn) else $error("converter off in conversion");
  a_mode_stable: assert property (@(posedge core_clk) disable iff (!reset_n)
    convActive && $past(convActive) |-> $stable(eightBitMode))
    else $error("mode changed in conversion");
  a_scl_hs_only: assert property (@(posedge linkClk) disable iff (!reset_n)
    sclOe |-> hsMode) else $error("stretch outside high-speed mode");
  a_sda_scl_low: assert property (@(posedge linkClk) disable iff (!reset_n)
    $changed(sdaOe) |-> !sclIn) else $error("SDA drive changed with SCL high");
endmodule
bind tac_i2c_port tac_i2c_port_props #(.BIT_CYCLES(BIT_CYCLES)) i_tac_i2c_port_props (.*);

// [tac_i2c_master.sv]
/* Two-wire bus master model; releases lines by driving high.
   Assumes the bench resolves each wire as the AND of the drive levels. */
`timescale 1ns/1ps
module tac_i2c_master (
  input  wire logic sclWire, // SCL wire level
  input  wire logic sdaWire, // SDA wire level
  output logic      sclDrv,  // SCL release when high
  output logic      sdaDrv   // SDA release when high
);
  localparam time Q = 40ns;
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  // Data set mid-low, sampled mid-high; a stretched clock is waited out
  task automatic bit_io(input logic b, output logic r);
    sdaDrv = b;
    #Q sclDrv = 1'b1;
    wait (sclWire);
    #Q r = sdaWire;
    #Q sclDrv = 1'b0;
    #Q;
  endtask
  task automatic start_cond;
    sdaDrv = 1'b1;
    #Q sclDrv = 1'b1;
    #Q sdaDrv = 1'b0;
    #Q sclDrv = 1'b0;
    #Q;
  endtask
  task automatic stop_cond;
    sdaDrv = 1'b0;
    #Q sclDrv = 1'b1;
    #Q sdaDrv = 1'b1;
    #Q;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic mAck, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(mAck, r);
  endtask
endmodule

// [tb.sv]
/* Self-checking bench of the command port driven by a bus master model.
   Assumes the checker binds itself to the port. */
`timescale 1ns/1ps
module tb;
  localparam logic [4:0] PFX = 5'h0d; // Arbitrary prefix
  localparam logic [1:0] SEL = 2'b10;
  typedef struct {
    logic [7:0] cmd; logic [11:0] adc; logic [7:0] b0, b1; logic [3:0] drv; logic [1:0] pwr;
  } tac_row_type;
  tac_row_type rows [5] = '{
    '{8'h00, 12'ha5c, 8'ha5, 8'hc0, 4'h0, 2'b00},
    '{8'hc2, 12'h3c7, 8'h3c, 8'h00, 4'hc, 2'b00},
    '{8'h58, 12'h001, 8'h00, 8'h10, 4'h0, 2'b10},
    '{8'h14, 12'h800, 8'h80, 8'h00, 4'h0, 2'b01},
    '{8'hfc, 12'hfff, 8'hff, 8'hf0, 4'h6, 2'b11}};
  logic        core_clk = 1'b0, linkClk = 1'b0, reset_n = 1'b0, sawStretch = 1'b0;
  logic        sclDrv, sdaDrv, sclOe, sdaOe, ack, muxEnable, convActive, hsMode;
  logic        refPowerOn, adcPowerOn, eightBitMode, refDifferential;
  logic [11:0] adcResult = 12'h000;
  logic [7:0]  d0;
  logic [3:0]  muxSel, panelDrivers, drvSeen;
  int          failures = 0, num_checks = 0;
  wire         sclIn = sclDrv & ~sclOe;
  wire         sdaIn = sdaDrv & ~sdaOe;
  always #50 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #3 linkClk = ~linkClk;
  end
  always @(posedge linkClk) if (sclOe === 1'b1) sawStretch <= 1'b1;
  tac_i2c_master i_tac_i2c_master (.sclWire(sclIn), .sdaWire(sdaIn), .sclDrv(sclDrv),
    .sdaDrv(sdaDrv));
  tac_i2c_port #(.ADDR_PREFIX(PFX), .BIT_CYCLES(2)) i_tac_i2c_port (
    .core_clk(core_clk), .reset_n(reset_n), .linkClk(linkClk), .sclIn(sclIn),
    .sclOut(), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe),
    .deviceSelectPins(SEL), .adcResult(adcResult), .muxSel(muxSel), .muxEnable(muxEnable),
    .panelDrivers(panelDrivers), .refDifferential(refDifferential),
    .convActive(convActive), .eightBitMode(eightBitMode), .refPowerOn(refPowerOn),
    .adcPowerOn(adcPowerOn), .hsMode(hsMode));
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic write_cmd(input logic [7:0] c);
    i_tac_i2c_master.start_cond();
    i_tac_i2c_master.wr_byte({PFX, SEL, 1'b0}, ack);
    chk_bit(ack, 1'b0);
    i_tac_i2c_master.wr_byte(c, ack);
    chk_bit(ack, 1'b0);
  endtask
  task automatic read_res(input logic [7:0] e0, input logic [7:0] e1, input logic ack1);
    i_tac_i2c_master.start_cond();
    i_tac_i2c_master.wr_byte({PFX, SEL, 1'b1}, ack);
    chk_bit(ack, 1'b0);
    i_tac_i2c_master.rd_byte(1'b0, d0);
    chk_val({4'h0, d0}, {4'h0, e0});
    i_tac_i2c_master.rd_byte(ack1, d0);
    chk_val({4'h0, d0}, {4'h0, e1});
  endtask
  task automatic wait_conv;
    for (int n = 0; n < 200 && convActive !== 1'b1; n++) @(negedge core_clk);
    chk_bit(convActive, 1'b1);
    drvSeen = panelDrivers;
    for (int n = 0; n < 200 && convActive !== 1'b0; n++) @(negedge core_clk);
    chk_bit(convActive, 1'b0);
    repeat (100) @(negedge core_clk);
  endtask
  initial begin
    #400us;
    failures++;
    complete_run();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk_val({8'h00, sclOe, sdaOe, convActive, hsMode}, 12'h000);
    foreach (rows[k]) begin
      adcResult = rows[k].adc;
      write_cmd(rows[k].cmd);
      chk_val({8'h00, muxSel}, {8'h00, rows[k].cmd[7:4]});
      chk_bit(refDifferential, rows[k].cmd[7]);
      chk_bit(muxEnable, 1'b1);
      i_tac_i2c_master.stop_cond();
      wait_conv();
      chk_val({8'h00, drvSeen}, {8'h00, rows[k].drv});
      read_res(rows[k].b0, rows[k].b1, 1'b1);
      i_tac_i2c_master.stop_cond();
      chk_val({10'h000, refPowerOn, adcPowerOn}, {10'h000, rows[k].pwr});
    end
    // Other select pins, then a surplus command byte
    i_tac_i2c_master.start_cond();
    i_tac_i2c_master.wr_byte({PFX, ~SEL, 1'b0}, ack);
    chk_bit(ack, 1'b1);
    adcResult = 12'h5a3;
    write_cmd(8'hd0);
    i_tac_i2c_master.wr_byte(8'h00, ack);
    chk_bit(ack, 1'b1);
    i_tac_i2c_master.stop_cond();
    wait_conv();
    chk_val({8'h00, drvSeen}, 12'h003);
    read_res(8'h5a, 8'h30, 1'b0);
    i_tac_i2c_master.rd_byte(1'b1, d0);
    chk_val({4'h0, d0}, 12'h05a);
    i_tac_i2c_master.stop_cond();
    // High-speed entry, then a read right behind the command
    i_tac_i2c_master.start_cond();
    i_tac_i2c_master.wr_byte(8'h0b, ack);
    chk_bit(ack, 1'b1);
    chk_bit(hsMode, 1'b1);
    adcResult = 12'h9e1;
    write_cmd(8'h00);
    read_res(8'h9e, 8'h10, 1'b1);
    chk_bit(sawStretch, 1'b1);
    i_tac_i2c_master.stop_cond();
    chk_bit(hsMode, 1'b0);
    complete_run();
  end
endmodule
